// File: rtl/rpbfc_sequencer.v
// Reset release, park handling and boot-flash loader
`timescale 1ns/1ps
`include "rpbfc_regs.vh"
module rpbfc_sequencer #(
	parameter BOOT_BYTES   = 16,
	parameter PARK_WIN_CYC = `RPBFC_PARK_WIN_CYC
) (
	input  wire       i_clk,
	input  wire       i_rstn,
	input  wire       i_park_n,
	input  wire       i_error,
	input  wire       i_flash_serial_in,
	output reg  [7:0] o_boot_data,
	output reg        o_boot_valid,
	output wire       o_park_active,
	output wire       o_park_late,
	output reg        o_init_done,
	output wire       o_mirror_array_power_enable,
	output wire       o_mirror_array_power_enable_oe,
	output wire       o_light_driver_on,
	output wire       o_light_driver_on_oe,
	output wire       o_light_source_select_lo,
	output wire       o_light_source_select_lo_oe,
	output wire       o_light_source_select_hi,
	output wire       o_light_source_select_hi_oe,
	output wire       o_flash_serial_clock,
	output wire       o_flash_serial_clock_oe,
	output wire       o_flash_serial_out,
	output wire       o_flash_serial_out_oe,
	output wire       o_flash_select_n,
	output wire       o_flash_select_n_oe
);
	// Loader states, binary coded
	// Idle waits for the first edge after reset release
	// Command shifts out the read opcode and start address
	// Data gathers boot bytes, most significant bit first
	// Done holds init-done high for a fixed count
	// Run keeps the flash port quiet and watches for errors
	localparam ST_IDLE = 3'h0;
	localparam ST_CMD  = 3'h1;
	localparam ST_DATA = 3'h2;
	localparam ST_DONE = 3'h3;
	localparam ST_RUN  = 3'h4;
	// Read opcode followed by the boot start address
	localparam [31:0] CMD_WORD = {`RPBFC_CMD_READ, `RPBFC_BOOT_ADDR};

	// Sequencer state and release marker
	reg [2:0]  state_reg;
	reg        rst_seen_reg;

	// Pin synchronisers and their filtered levels
	reg [2:0]  park_sync_reg;
	reg        park_n_reg;
	reg [2:0]  err_sync_reg;
	reg        err_level_reg;

	// Serial engine towards the flash
	reg [31:0] shift_reg;
	reg [5:0]  bit_cnt_reg;
	reg        sclk_reg;
	reg        cs_n_reg;

	// Receive side and counters
	reg [7:0]  rx_reg;
	reg [15:0] byte_cnt_reg;
	reg [2:0]  pulse_cnt_reg;

	// Park window watch
	reg [31:0] win_cnt_reg;
	reg        late_reg;
	wire       drive_en;
	wire       err_rise;

	// All pin drivers released while reset is low
	// Enables rise one edge after release, so the board pulls
	// still define the pins during that first cycle
	assign drive_en = rst_seen_reg;
	assign o_mirror_array_power_enable_oe = drive_en;
	assign o_light_driver_on_oe           = drive_en;
	assign o_light_source_select_lo_oe    = drive_en;
	assign o_light_source_select_hi_oe    = drive_en;
	assign o_flash_serial_clock_oe        = drive_en;
	assign o_flash_serial_out_oe          = drive_en;
	assign o_flash_select_n_oe            = drive_en;

	// Mirror power and light drive only when running and not parked
	// Kept combinational so the filtered park level cuts drive with no further flop
	// Light selects are not used by this block and stay low
	assign o_park_active = ~park_n_reg;
	assign o_park_late   = late_reg;
	assign o_mirror_array_power_enable = (state_reg == ST_RUN) & park_n_reg;
	assign o_light_driver_on           = (state_reg == ST_RUN) & park_n_reg;
	assign o_light_source_select_lo    = 1'b0;
	assign o_light_source_select_hi    = 1'b0;
	assign o_flash_serial_clock = sclk_reg;
	assign o_flash_serial_out   = shift_reg[31];
	assign o_flash_select_n     = cs_n_reg;

	// Pin inputs: three flops, change accepted when stages two and three agree
	// Stage one is never read directly, it may still be metastable
	// The agreeing pair filters one-cycle glitches on the pins
	assign err_rise = (err_sync_reg[2:1] == 2'b11) & ~err_level_reg;
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			park_sync_reg <= 3'h0;
			park_n_reg    <= 1'b0;
			err_sync_reg  <= 3'h0;
			err_level_reg <= 1'b0;
		end else begin
			park_sync_reg <= {park_sync_reg[1:0], i_park_n};
			err_sync_reg  <= {err_sync_reg[1:0], i_error};
			if (park_sync_reg[2] == park_sync_reg[1])
				park_n_reg <= park_sync_reg[2];
			if (err_sync_reg[2] == err_sync_reg[1])
				err_level_reg <= err_sync_reg[2];
		end
	end

	// Park window watch: host should release park soon after reset release
	// Counts from release whatever park does, then judges park once
	// A later park for power-down must not raise the late flag
	// The flag is advisory and sticky until the next reset
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			win_cnt_reg <= 32'h0;
			late_reg    <= 1'b0;
		end else if (win_cnt_reg < PARK_WIN_CYC) begin
			win_cnt_reg <= win_cnt_reg + 32'h1;
		end else if (win_cnt_reg == PARK_WIN_CYC) begin
			late_reg    <= ~park_n_reg;
			win_cnt_reg <= win_cnt_reg + 32'h1;
		end
	end

	// Flash loader; serial clock is system clock divided by two
	// Mode 0: data launched on falling, sampled on rising clock
	// One load per reset, nothing restarts it afterwards
	always @(posedge i_clk) begin
		if (!i_rstn) begin
			state_reg     <= ST_IDLE;
			rst_seen_reg  <= 1'b0;
			shift_reg     <= 32'h0;
			bit_cnt_reg   <= 6'h0;
			sclk_reg      <= 1'b0;
			cs_n_reg      <= 1'b1;
			rx_reg        <= 8'h0;
			byte_cnt_reg  <= 16'h0;
			pulse_cnt_reg <= 3'h0;
			o_init_done   <= 1'b0;
			o_boot_data   <= 8'h0;
			o_boot_valid  <= 1'b0;
		end else begin
			rst_seen_reg <= 1'b1;
			o_boot_valid <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				// Edge of reset release starts configuration
				if (!rst_seen_reg) begin
					state_reg   <= ST_CMD;
					cs_n_reg    <= 1'b0;
					shift_reg   <= CMD_WORD;
					bit_cnt_reg <= 6'h0;
				end
			end
			ST_CMD: begin
				// Shift on the falling serial clock edge
				// The flash sees each bit one system clock cycle, half a serial clock, before it samples
				sclk_reg <= ~sclk_reg;
				if (sclk_reg) begin
					shift_reg <= {shift_reg[30:0], 1'b0};
					if (bit_cnt_reg == 6'h1F) begin
						bit_cnt_reg <= 6'h0;
						state_reg   <= ST_DATA;
					end else
						bit_cnt_reg <= bit_cnt_reg + 6'h1;
				end
			end
			ST_DATA: begin
				sclk_reg <= ~sclk_reg;
				// Sample on rising serial clock
				if (!sclk_reg) begin
					rx_reg <= {rx_reg[6:0], i_flash_serial_in};
					if (bit_cnt_reg == 6'h07) begin
						bit_cnt_reg  <= 6'h0;
						o_boot_data  <= {rx_reg[6:0], i_flash_serial_in};
						o_boot_valid <= 1'b1;
						byte_cnt_reg <= byte_cnt_reg + 16'h1;
					end else
						bit_cnt_reg <= bit_cnt_reg + 6'h1;
				end else if (byte_cnt_reg == BOOT_BYTES[15:0]) begin
					// Close on the falling edge after the last byte
					cs_n_reg      <= 1'b1;
					state_reg     <= ST_DONE;
					o_init_done   <= 1'b1;
					pulse_cnt_reg <= 3'h0;
				end
			end
			ST_DONE: begin
				// Init-done stands a fixed count, then run begins
				// Errors whose filtered level rises here are never flagged, not even in run
				pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
				if (pulse_cnt_reg == `RPBFC_DONE_PULSE - 1) begin
					o_init_done <= 1'b0;
					state_reg   <= ST_RUN;
				end
			end
			ST_RUN: begin
				// Errors reuse init-done as a short pulse
				// One cycle per rising error level, so a held error flags once
				cs_n_reg <= 1'b1;
				sclk_reg <= 1'b0;
				o_init_done <= err_rise;
			end
			// Unused codes fall back to idle
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// File: rtl/rpbfc_regs.vh
// Constants for the reset, park and boot-flash sequencer
`ifndef RPBFC_REGS_VH
`define RPBFC_REGS_VH
`define RPBFC_CLK_HZ       25000000
`define RPBFC_PARK_WIN_US  500
`define RPBFC_PARK_WIN_CYC ((`RPBFC_PARK_WIN_US * (`RPBFC_CLK_HZ / 1000000)))
`define RPBFC_CMD_READ     8'h03
`define RPBFC_CMD_W        8
`define RPBFC_ADDR_W       24
`define RPBFC_BOOT_ADDR    24'h000000
`define RPBFC_DONE_PULSE   4
`define RPBFC_CMD_START    0
`define RPBFC_CMD_LEN      32
`endif

// File: testbench/rpbfc_flash_model.sv
// Behavioural serial flash answering the boot read
`timescale 1ns/1ps
module rpbfc_flash_model (
	input  wire        i_clk,
	input  wire        i_sclk,
	input  wire        i_sel_n,
	input  wire        i_sdi,
	output wire        o_sdo,
	output reg  [31:0] o_cmd
);
	reg [7:0] cnt_reg = 8'h00;
	reg       bit_reg = 1'b0;
	reg       idle_reg = 1'b0;
	reg [7:0] byte_v;
	// Catch command bits on rising clock while selected
	always @(posedge i_sclk or posedge i_sel_n) begin
		if (i_sel_n)
			cnt_reg <= 8'h00;
		else begin
			if (cnt_reg < 8'h20)
				o_cmd <= {o_cmd[30:0], i_sdi};
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
	// Data byte k is A5 xor k, launched on falling clock
	always @(negedge i_sclk) begin
		byte_v = 8'hA5 ^ ((cnt_reg - 8'h20) >> 3);
		if (cnt_reg >= 8'h20)
			bit_reg <= byte_v[3'h7 - cnt_reg[2:0]];
	end
	// Toggles when deselected so stale data never looks valid
	always @(posedge i_clk) idle_reg <= ~idle_reg;
	assign o_sdo = i_sel_n ? idle_reg : bit_reg;
endmodule

// File: testbench/rpbfc_sva.sv
// Checker for reset, park and boot-flash port behaviour
`timescale 1ns/1ps
module rpbfc_sva (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_park_n,
	input wire logic i_error,
	input wire logic o_init_done,
	input wire logic o_park_active,
	input wire logic o_light_driver_on,
	input wire logic o_flash_serial_clock,
	input wire logic o_flash_serial_out,
	input wire logic o_flash_select_n,
	input wire logic o_flash_serial_clock_oe,
	input wire logic o_flash_select_n_oe
);
	reg seen_reg;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Marks the end of the first done phase
	always @(posedge i_clk)
		if (!i_rstn) seen_reg <= 1'b0;
		else if ($fell(o_init_done)) seen_reg <= 1'b1;
	a_float_rst: assert property (disable iff (1'b0) !i_rstn |=> !o_flash_select_n_oe && !o_flash_serial_clock_oe)
		else $error("pins driven in reset");
	a_start_rel: assert property ($rose(i_rstn) |-> ##[1:2] !o_flash_select_n)
		else $error("no load after release");
	a_park_req: assert property (!i_park_n [*5] |-> o_park_active && !o_light_driver_on)
		else $error("park ignored");
	a_sel_idle: assert property (o_init_done |-> o_flash_select_n)
		else $error("select low when idle");
	a_sclk_idle: assert property (o_flash_select_n && $past(o_flash_select_n) |-> $stable(o_flash_serial_clock))
		else $error("clock moves unselected");
	a_sdo_fall: assert property (!o_flash_select_n && !$past(o_flash_select_n) && !$stable(o_flash_serial_out)
		|-> $fell(o_flash_serial_clock)) else $error("data not on falling");
	a_done_len: assert property ($rose(o_init_done) && !seen_reg |-> o_init_done [*4] ##1 !o_init_done)
		else $error("done width wrong");
	a_err_pulse: assert property (seen_reg && $rose(i_error) |-> ##[1:6] o_init_done)
		else $error("error not flagged");
endmodule
bind rpbfc_sequencer rpbfc_sva rpbfc_sva_inst (.*);

// File: testbench/rpbfc_sequencer_tb.sv
// Self-checking bench for the boot sequencer
`timescale 1ns/1ps
module rpbfc_sequencer_tb;
	reg i_clk = 0, i_rstn = 0, i_park_n = 1, i_error = 0;
	wire [7:0] o_boot_data;
	wire o_boot_valid, o_park_active, o_park_late, o_init_done, o_flash_serial_clock, o_flash_serial_out;
	wire o_flash_select_n, o_flash_serial_clock_oe, o_flash_serial_out_oe, o_flash_select_n_oe, i_flash_serial_in;
	wire o_mirror_array_power_enable, o_mirror_array_power_enable_oe, o_light_driver_on, o_light_driver_on_oe;
	wire o_light_source_select_lo, o_light_source_select_lo_oe, o_light_source_select_hi, o_light_source_select_hi_oe;
	wire [31:0] cmd;
	integer fail_count = 0, checked = 0, k, b;
	// Board pulls: clock down, select up while pins float
	wire sck = o_flash_serial_clock_oe ? o_flash_serial_clock : 1'b0;
	wire sel = o_flash_select_n_oe ? o_flash_select_n : 1'b1;
	rpbfc_sequencer #(.BOOT_BYTES(2), .PARK_WIN_CYC(20)) rpbfc_sequencer_inst (.*);
	rpbfc_flash_model rpbfc_flash_model_inst (.i_clk(i_clk), .i_sclk(sck), .i_sel_n(sel),
		.i_sdi(o_flash_serial_out), .o_sdo(i_flash_serial_in), .o_cmd(cmd));
	initial forever #20 i_clk = ~i_clk;
	task chk(input bit ok, input string m);
		checked++;
		if (!ok) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task final_report;
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Boot with park held low past its window
	task t_boot;
		k = 0;
		b = 0;
		i_park_n <= 0;
		i_rstn <= 1;
		while (o_init_done !== 1'b1 && k < 400) begin
			@(negedge i_clk);
			k++;
			if (o_boot_valid === 1'b1) begin
				chk(o_boot_data === (8'hA5 ^ b), "boot byte");
				b++;
			end
		end
		chk(b == 2 && cmd === 32'h03000000, "boot read");
		chk(o_park_late === 1'b1, "late park");
		for (k = 0; o_init_done === 1'b1 && k < 9; k++) begin
			chk(sel === 1'b1, "select idle");
			@(negedge i_clk);
		end
		chk(k == 4, "done width");
	endtask
	// Park release, then park request
	task t_park;
		@(posedge i_clk);
		i_park_n <= 1;
		repeat (6) @(negedge i_clk);
		chk(o_park_active === 1'b0 && o_mirror_array_power_enable === 1'b1, "run");
		chk(o_light_source_select_lo === 1'b0 && o_light_source_select_hi === 1'b0, "selects");
		@(posedge i_clk);
		i_park_n <= 0;
		repeat (6) @(negedge i_clk);
		chk(o_park_active === 1'b1 && o_light_driver_on === 1'b0, "park");
	endtask
	// Error raised after init shows on done
	task t_err;
		@(posedge i_clk);
		i_error <= 1;
		for (k = 0; o_init_done !== 1'b1 && k < 10; k++) @(negedge i_clk);
		chk(k < 10, "error pulse");
		@(posedge i_clk);
		i_error <= 0;
	endtask
	initial begin
		repeat (20) @(negedge i_clk);
		chk(o_flash_select_n_oe === 1'b0 && o_flash_serial_clock_oe === 1'b0 && o_flash_serial_out_oe === 1'b0, "float");
		chk(o_mirror_array_power_enable_oe === 1'b0 && o_light_driver_on_oe === 1'b0, "float pwr");
		chk(o_light_source_select_lo_oe === 1'b0 && o_light_source_select_hi_oe === 1'b0, "float sel");
		@(posedge i_clk);
		t_boot;
		t_park;
		t_err; // Park stays low before power goes
		final_report;
	end
	// Run should finish in well under 1000 cycles
	initial begin
		#100000;
		fail_count++;
		final_report;
	end
endmodule
